// ---- dbseq_regs.svh ----
// Register offsets, field positions, reset values and timing constants.
`ifndef DBSEQ_REGS_SVH
`define DBSEQ_REGS_SVH

`define DBSEQ_ADDR_W          8
`define DBSEQ_OFS_CYCLIC      8'h08
`define DBSEQ_OFS_PINSEL      8'h09
`define DBSEQ_OFS_RAILCTL     8'h0C
`define DBSEQ_OFS_BOOSTDLY    8'h0D
`define DBSEQ_OFS_POSLVL      8'h0E
`define DBSEQ_OFS_NEGLVL      8'h0F

`define DBSEQ_BIT_CYC_EN      7
`define DBSEQ_BIT_CYC_RATE    6
`define DBSEQ_BIT_PIN_SEL     5
`define DBSEQ_BIT_PWR_SAVE    7
`define DBSEQ_BIT_POS_EN      6
`define DBSEQ_BIT_POS_GND     5
`define DBSEQ_BIT_POS_DISC    4
`define DBSEQ_BIT_NEG_EN      3
`define DBSEQ_BIT_NEG_GND     2
`define DBSEQ_BIT_NEG_DISC    1
`define DBSEQ_DLY_HI          7
`define DBSEQ_DLY_LO          6
`define DBSEQ_LVL_HI          5

`define DBSEQ_RST_CYCLIC      8'h00
`define DBSEQ_RST_PINSEL      8'h00
`define DBSEQ_RST_RAILCTL     8'h24
`define DBSEQ_RST_BOOSTDLY    8'h28
`define DBSEQ_RST_POSLVL      8'h5E
`define DBSEQ_RST_NEGLVL      8'h9C

`define DBSEQ_CLK_KHZ         50000
`define DBSEQ_US(x)           ((x) * `DBSEQ_CLK_KHZ / 1000)
`define DBSEQ_T_1MS_US        1000
`define DBSEQ_T_2MS_US        2000
`define DBSEQ_T_5MS_US        5000
`define DBSEQ_T_DISC_US       20000
`define DBSEQ_T_ON_SLOW_US    2000
`define DBSEQ_T_PER_SLOW_US   50000
`define DBSEQ_T_ON_FAST_US    1600
`define DBSEQ_T_PER_FAST_US   30000

`endif

// ---- dbseq_pkg.sv ----
// Types shared by the display bias sequencer.
package dbseq_pkg;
  typedef enum logic [1:0] {
    DBSEQ_DLY_NONE,
    DBSEQ_DLY_1MS,
    DBSEQ_DLY_2MS,
    DBSEQ_DLY_5MS
  } dbseq_dly_e;

  typedef enum logic [2:0] {
    RAIL_OFF,
    RAIL_RAMP,
    RAIL_ON,
    RAIL_DISC,
    RAIL_GND
  } dbseq_rail_e;

  typedef struct packed {
    logic       run;
    logic       disc;
    logic       hold_gnd;
    logic       bypass;
    logic [5:0] code;
  } dbseq_rail_s;
endpackage : dbseq_pkg

// ---- dbseq_rail.sv ----
// One output rail: ramp, on, discharge and ground-hold phases.
`timescale 1ns/1ps
`include "dbseq_regs.svh"
module dbseq_rail
  import dbseq_pkg::*;
#(
  parameter int DISC_CYC = `DBSEQ_US(`DBSEQ_T_DISC_US)
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        run_req,
  input  wire logic        disc_en,
  input  wire logic        gnd_en,
  input  wire logic        ramp_done,
  // Status
  output dbseq_rail_e      state,
  output logic             at_target,
  output logic             at_ground,
  output logic             disc_on,
  output logic             gnd_on
);
  dbseq_rail_e      st_r;
  dbseq_rail_e      st_nxt;
  logic [31:0]      cnt_r;
  logic [31:0]      cnt_nxt;
  wire logic        disc_done = (cnt_r >= 32'(DISC_CYC - 1));

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = 32'h0;
    case (st_r)
      RAIL_OFF, RAIL_GND: begin
        if (run_req) begin
          st_nxt = RAIL_RAMP;
        end
      end
      RAIL_RAMP: begin
        if (!run_req) begin
          st_nxt = disc_en ? RAIL_DISC : RAIL_OFF;
        end else if (ramp_done) begin
          st_nxt = RAIL_ON;
        end
      end
      RAIL_ON: begin
        if (!run_req) begin
          st_nxt = disc_en ? RAIL_DISC : RAIL_OFF;
        end
      end
      RAIL_DISC: begin
        cnt_nxt = cnt_r + 32'h1;
        if (run_req) begin
          st_nxt = RAIL_RAMP;
        end else if (disc_done) begin
          st_nxt = RAIL_GND;
        end
      end
      default: st_nxt = RAIL_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= RAIL_OFF;
      cnt_r <= 32'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign state     = st_r;
  assign at_target = (st_r == RAIL_ON);
  // A rail without discharge floats and counts as at ground once off.
  assign at_ground = (st_r == RAIL_OFF) || (st_r == RAIL_GND);
  assign disc_on   = (st_r == RAIL_DISC);
  assign gnd_on    = gnd_en && !run_req && (st_r == RAIL_GND);
endmodule : dbseq_rail

// ---- dbseq_top.sv ----
// Display bias sequencer: enable decode, rail ordering, periodic mode.
// Summary of operation
// - Pin select: rails follow pins.
// - Master enable low forces shutdown.
// - Register select: rails follow enable bits.
// - Six-bit level codes, 50 mV step.
// - Reset levels 6 V, 5.5 V, -5.4 V.
// - Discharge switch closes at turn-off.
// - Ground-hold keeps discharged rail grounded.
// - Power saving bypasses input to rails.
// - Two-bit delay: none, 1, 2, 5 ms.
// - No delay: each rail starts independently.
// - No delay: each rail discharges independently.
// - Negative starts after positive plus delay.
// - Positive stops after negative grounded plus delay.
// - Periodic mode toggles enabled rails.
// - Periodic 2/50 ms or 1.6/30 ms.
// - Periodic cycles use normal sequencing.
// - Discharge lasts 20 ms.
// - Ground-hold never shorts a running rail.
`timescale 1ns/1ps
`include "dbseq_regs.svh"
module dbseq_top
  import dbseq_pkg::*;
#(
  parameter int D1_CYC    = `DBSEQ_US(`DBSEQ_T_1MS_US),
  parameter int D2_CYC    = `DBSEQ_US(`DBSEQ_T_2MS_US),
  parameter int D5_CYC    = `DBSEQ_US(`DBSEQ_T_5MS_US),
  parameter int DISC_CYC  = `DBSEQ_US(`DBSEQ_T_DISC_US),
  parameter int ONS_CYC   = `DBSEQ_US(`DBSEQ_T_ON_SLOW_US),
  parameter int PERS_CYC  = `DBSEQ_US(`DBSEQ_T_PER_SLOW_US),
  parameter int ONF_CYC   = `DBSEQ_US(`DBSEQ_T_ON_FAST_US),
  parameter int PERF_CYC  = `DBSEQ_US(`DBSEQ_T_PER_FAST_US)
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Enable pins
  input  wire logic        master_enable_pin,
  input  wire logic        plus_enable_pin,
  input  wire logic        minus_enable_pin,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Ramp completion from the analog regulators
  input  wire logic        pos_ramp_done,
  input  wire logic        neg_ramp_done,
  // Rail controls
  output dbseq_rail_s      boost_rail,
  output dbseq_rail_s      positive_rail,
  output dbseq_rail_s      negative_rail,
  output logic             shutdown
);
  logic [7:0]   cyc_r;
  logic [7:0]   pinsel_r;
  logic [7:0]   ctl_r;
  logic [7:0]   bdl_r;
  logic [7:0]   pos_r;
  logic [7:0]   neg_r;
  logic [31:0]  dly_cnt_r;
  logic [31:0]  dly_cnt_nxt;
  logic [31:0]  per_cnt_r;
  logic [7:0]   rdata_nxt;
  logic [7:0]   rdata_r;
  dbseq_rail_e  pos_st;
  logic         pos_tgt;
  logic         neg_tgt;
  logic         pos_gnd_ok;
  logic         neg_gnd_ok;
  logic         pos_disc;
  logic         neg_disc;
  logic         pos_hold;
  logic         neg_hold;

  function automatic logic [31:0] dly_cycles(input logic [1:0] code);
    case (dbseq_dly_e'(code))
      DBSEQ_DLY_1MS: dly_cycles = 32'(D1_CYC);
      DBSEQ_DLY_2MS: dly_cycles = 32'(D2_CYC);
      DBSEQ_DLY_5MS: dly_cycles = 32'(D5_CYC);
      default:       dly_cycles = 32'h0;
    endcase
  endfunction : dly_cycles

  // Register writes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r    <= `DBSEQ_RST_CYCLIC;
      pinsel_r <= `DBSEQ_RST_PINSEL;
      ctl_r    <= `DBSEQ_RST_RAILCTL;
      bdl_r    <= `DBSEQ_RST_BOOSTDLY;
      pos_r    <= `DBSEQ_RST_POSLVL;
      neg_r    <= `DBSEQ_RST_NEGLVL;
    end else if (reg_wr) begin
      case (reg_addr)
        `DBSEQ_OFS_CYCLIC:   cyc_r    <= reg_wdata;
        `DBSEQ_OFS_PINSEL:   pinsel_r <= reg_wdata;
        `DBSEQ_OFS_RAILCTL:  ctl_r    <= reg_wdata;
        `DBSEQ_OFS_BOOSTDLY: bdl_r    <= reg_wdata;
        `DBSEQ_OFS_POSLVL:   pos_r    <= reg_wdata;
        `DBSEQ_OFS_NEGLVL:   neg_r    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped offsets read zero.
  always_comb begin
    case (reg_addr)
      `DBSEQ_OFS_CYCLIC:   rdata_nxt = cyc_r;
      `DBSEQ_OFS_PINSEL:   rdata_nxt = pinsel_r;
      `DBSEQ_OFS_RAILCTL:  rdata_nxt = ctl_r;
      `DBSEQ_OFS_BOOSTDLY: rdata_nxt = bdl_r;
      `DBSEQ_OFS_POSLVL:   rdata_nxt = pos_r;
      `DBSEQ_OFS_NEGLVL:   rdata_nxt = neg_r;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // Decoded fields.
  wire logic       pin_mode  = pinsel_r[`DBSEQ_BIT_PIN_SEL];
  wire logic       cyc_en    = cyc_r[`DBSEQ_BIT_CYC_EN];
  wire logic       cyclic_rate_select = cyc_r[`DBSEQ_BIT_CYC_RATE];
  wire logic       pwr_save  = ctl_r[`DBSEQ_BIT_PWR_SAVE];
  wire logic [1:0] dly_code  = bdl_r[`DBSEQ_DLY_HI:`DBSEQ_DLY_LO];
  wire logic       ordered   = (dly_code != 2'b00);
  wire logic [31:0] dly_need = dly_cycles(dly_code);

  assign shutdown = !master_enable_pin;
  wire logic pin_pos = plus_enable_pin;
  wire logic pin_neg = minus_enable_pin;
  wire logic reg_pos = ctl_r[`DBSEQ_BIT_POS_EN];
  wire logic reg_neg = ctl_r[`DBSEQ_BIT_NEG_EN];
  wire logic req_pos = master_enable_pin && (pin_mode ? pin_pos : reg_pos);
  wire logic req_neg = master_enable_pin && (pin_mode ? pin_neg : reg_neg);

  wire logic [31:0] per_len = cyclic_rate_select ? 32'(PERF_CYC)
                                                 : 32'(PERS_CYC);
  wire logic [31:0] on_len  = cyclic_rate_select ? 32'(ONF_CYC)
                                                 : 32'(ONS_CYC);
  wire logic        per_on  = !cyc_en || (per_cnt_r < on_len);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= 32'h0;
    end else if (!cyc_en || per_cnt_r >= per_len - 32'h1) begin
      per_cnt_r <= 32'h0;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Periodic gating feeds the normal sequencer.
  wire logic want_pos = req_pos && per_on;
  wire logic want_neg = req_neg && per_on;

  // Inter-rail delay timer: counts while its start condition holds.
  // Positive at target starts the up delay; negative at ground with
  // positive still wanted off starts the down delay.
  wire logic up_cond   = ordered && pos_tgt && want_neg;
  wire logic down_cond = ordered && !want_pos && neg_gnd_ok;
  wire logic dly_done  = (dly_cnt_r >= dly_need);

  always_comb begin
    dly_cnt_nxt = 32'h0;
    if ((up_cond || down_cond) && !dly_done) begin
      dly_cnt_nxt = dly_cnt_r + 32'h1;
    end else if (up_cond || down_cond) begin
      dly_cnt_nxt = dly_cnt_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_r <= 32'h0;
    end else begin
      dly_cnt_r <= dly_cnt_nxt;
    end
  end

  // Negative waits for positive plus delay.
  // Code 10 follows same up order.
  wire logic run_neg = ordered ? (want_neg && pos_tgt && dly_done)
                                 || (want_neg && neg_tgt)
                               : want_neg;
  // Positive held until negative down plus delay.
  wire logic pos_stay = ordered && !want_pos && !pos_gnd_ok
                        && pos_st != RAIL_DISC
                        && !(neg_gnd_ok && dly_done);
  wire logic run_pos = master_enable_pin && (want_pos || pos_stay);

  dbseq_rail #(.DISC_CYC(DISC_CYC)) u_pos (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .run_req   (run_pos),
    .disc_en   (ctl_r[`DBSEQ_BIT_POS_DISC]),
    .gnd_en    (ctl_r[`DBSEQ_BIT_POS_GND]),
    .ramp_done (pos_ramp_done || pwr_save),
    .state     (pos_st),
    .at_target (pos_tgt),
    .at_ground (pos_gnd_ok),
    .disc_on   (pos_disc),
    .gnd_on    (pos_hold)
  );

  dbseq_rail #(.DISC_CYC(DISC_CYC)) u_neg (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .run_req   (run_neg),
    .disc_en   (ctl_r[`DBSEQ_BIT_NEG_DISC]),
    .gnd_en    (ctl_r[`DBSEQ_BIT_NEG_GND]),
    .ramp_done (neg_ramp_done || pwr_save),
    .state     (),
    .at_target (neg_tgt),
    .at_ground (neg_gnd_ok),
    .disc_on   (neg_disc),
    .gnd_on    (neg_hold)
  );

  // Six-bit level codes drive the regulators.
  // Power saving forces bypass on the up rails.
  always_comb begin
    boost_rail.run         = run_pos || run_neg;
    boost_rail.disc        = 1'b0;
    boost_rail.hold_gnd    = 1'b0;
    boost_rail.bypass      = pwr_save && (run_pos || run_neg);
    boost_rail.code        = bdl_r[`DBSEQ_LVL_HI:0];
    positive_rail.run      = run_pos;
    positive_rail.disc     = pos_disc;
    positive_rail.hold_gnd = pos_hold;
    positive_rail.bypass   = pwr_save && run_pos;
    positive_rail.code     = pos_r[`DBSEQ_LVL_HI:0];
    negative_rail.run      = run_neg;
    negative_rail.disc     = neg_disc;
    negative_rail.hold_gnd = neg_hold;
    negative_rail.bypass   = pwr_save && run_neg;
    negative_rail.code     = neg_r[`DBSEQ_LVL_HI:0];
  end
endmodule : dbseq_top

// ---- dbseq_props.sv ----
// Port assertions for the display bias sequencer.
`timescale 1ns/1ps
`include "dbseq_regs.svh"
module dbseq_props
  import dbseq_pkg::*;
#(
  parameter int DISC_CYC = 20
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Pins and register writes
  input wire logic        master_enable_pin,
  input wire logic        plus_enable_pin,
  input wire logic        minus_enable_pin,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        pos_ramp_done,
  // Rail controls
  input wire dbseq_rail_s boost_rail,
  input wire dbseq_rail_s positive_rail,
  input wire dbseq_rail_s negative_rail,
  input wire logic        shutdown
);
  localparam int DISC_LIM = DISC_CYC + 4;
  logic [7:0] ctl_r;
  logic [1:0] dly_r;
  logic       pin_r;
  logic       cyc_r;
  wire        free = master_enable_pin && dly_r == 2'h0 && !cyc_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow copies tell the properties which enable mode is in force.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 8'h24;
      dly_r <= 2'h0;
      pin_r <= 1'b0;
      cyc_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `DBSEQ_OFS_RAILCTL) ctl_r <= reg_wdata;
      if (reg_addr == `DBSEQ_OFS_BOOSTDLY) dly_r <= reg_wdata[7:6];
      if (reg_addr == `DBSEQ_OFS_PINSEL) pin_r <= reg_wdata[5];
      if (reg_addr == `DBSEQ_OFS_CYCLIC) cyc_r <= reg_wdata[7];
    end
  end
  sequence s_disc_held;
    (positive_rail.disc || positive_rail.run) [*8];
  endsequence
  shut_master_a: assert property (
    shutdown == !master_enable_pin &&
    (master_enable_pin || !(positive_rail.run || negative_rail.run)))
    else $error("shutdown state wrong");
  reg_mode_a: assert property (
    free && !pin_r |-> positive_rail.run == ctl_r[6] &&
    negative_rail.run == ctl_r[3]) else $error("register enable wrong");
  pin_mode_a: assert property (
    free && pin_r |-> positive_rail.run == plus_enable_pin &&
    negative_rail.run == minus_enable_pin) else $error("pin enable wrong");
  hold_gnd_a: assert property (
    !(positive_rail.hold_gnd && (positive_rail.run || !ctl_r[5])) &&
    !(negative_rail.hold_gnd && (negative_rail.run || !ctl_r[2])))
    else $error("ground hold wrong");
  disc_bit_a: assert property (
    !(positive_rail.disc && !ctl_r[4]) && !(negative_rail.disc && !ctl_r[1]))
    else $error("discharge without enable bit");
  reset_codes_a: assert property (
    $rose(rst_n) |-> boost_rail.code == 6'h28 &&
    positive_rail.code == 6'h1E && negative_rail.code == 6'h1C)
    else $error("reset level codes wrong");
  level_wr_a: assert property (
    reg_wr && reg_addr == `DBSEQ_OFS_POSLVL |=>
    {2'h0, positive_rail.code} == ($past(reg_wdata) & 8'h3F))
    else $error("level code not taken");
  order_up_a: assert property (
    $rose(negative_rail.run) && dly_r != 2'h0 |->
    positive_rail.run && $past(pos_ramp_done, 3))
    else $error("negative rail started early");
  order_dn_a: assert property (
    master_enable_pin && $fell(positive_rail.run) && dly_r != 2'h0 |->
    !negative_rail.run && !$past(negative_rail.run, 3))
    else $error("positive rail stopped early");
  disc_stand_a: assert property (
    $rose(positive_rail.disc) |-> s_disc_held)
    else $error("discharge ended early");
  disc_end_a: assert property (
    $rose(positive_rail.disc) |-> ##[1:DISC_LIM] !positive_rail.disc)
    else $error("discharge never ended");
endmodule : dbseq_props

// ---- dbseq_ana.sv ----
// Regulator model: reports a rail at target a set time after it runs.
`timescale 1ns/1ps
module dbseq_ana #(
  parameter int LAT = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic     done
);
  logic [3:0] cnt_r;
  // The ramp restarts from zero whenever the rail is dropped.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 4'h0;
    else if (!run) cnt_r <= 4'h0;
    else if (cnt_r != 4'(LAT)) cnt_r <= cnt_r + 4'h1;
  end
  assign done = (cnt_r == 4'(LAT));
endmodule : dbseq_ana

// ---- display_bias_sequencer_tb.sv ----
// Self-checking bench for the display bias sequencer.
`timescale 1ns/1ps
module display_bias_sequencer_tb;
  import dbseq_pkg::*;
  logic        core_clk, rst_n, master_enable_pin;
  logic        plus_enable_pin, minus_enable_pin, reg_wr, reg_rd;
  logic        pos_ramp_done, neg_ramp_done, shutdown;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  dbseq_rail_s boost_rail, positive_rail, negative_rail;
  int          err_count, tests_run, seed, n, k, d;
  // Shortened timing so every delay and period fits a short run.
  localparam int T_D1   = 4;
  localparam int T_D2   = 8;
  localparam int T_D5   = 12;
  localparam int T_DISC = 20;
  localparam int T_ONS  = 3;
  localparam int T_PERS = 20;
  localparam int T_ONF  = 2;
  localparam int T_PERF = 12;
  localparam int T_NLAT = 5;
  dbseq_top #(.D1_CYC(T_D1), .D2_CYC(T_D2), .D5_CYC(T_D5),
    .DISC_CYC(T_DISC), .ONS_CYC(T_ONS), .PERS_CYC(T_PERS),
    .ONF_CYC(T_ONF), .PERF_CYC(T_PERF)) uut (
    .core_clk(core_clk), .rst_n(rst_n),
    .master_enable_pin(master_enable_pin),
    .plus_enable_pin(plus_enable_pin), .minus_enable_pin(minus_enable_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pos_ramp_done(pos_ramp_done), .neg_ramp_done(neg_ramp_done),
    .boost_rail(boost_rail), .positive_rail(positive_rail),
    .negative_rail(negative_rail), .shutdown(shutdown));
  // The negative regulator is the slow one.
  dbseq_ana pos_ana (.core_clk(core_clk), .rst_n(rst_n),
    .run(positive_rail.run), .done(pos_ramp_done));
  dbseq_ana #(.LAT(T_NLAT)) neg_ana (.core_clk(core_clk), .rst_n(rst_n),
    .run(negative_rail.run), .done(neg_ramp_done));
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h0C: return 8'h24;
      8'h0D: return 8'h28;
      8'h0E: return 8'h5E;
      8'h0F: return 8'h9C;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  function automatic int dly_cyc(input int c);
    return (c == 1) ? T_D1 : (c == 2) ? T_D2 : (c == 3) ? T_D5 : 0;
  endfunction : dly_cyc
  task automatic tick(input int t);
    repeat (t) @(negedge core_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    // An idle edge keeps a following request out of this time step.
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    chk("rdata", e, reg_rdata);
    tick(1);
  endtask : rd
  task automatic final_report;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    seed = 32'h1913082C;
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    master_enable_pin = 1'b1;
    plus_enable_pin = 1'b0;
    minus_enable_pin = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    tick(10);
    rst_n = 1'b1;
    for (n = 8; n < 17; n++) rd(8'(n), rst_val(8'(n)));
    chk("boost code", 8'h28, {2'h0, boost_rail.code});
    chk("neg code", 8'h1C, {2'h0, negative_rail.code});
    repeat (6) begin
      v = 8'($random(seed));
      wr(8'h0E, v);
      wr(8'h0F, ~v);
      wr(8'h0D, {2'h0, v[5:0]});
      chk("boost code", v & 8'h3F, {2'h0, boost_rail.code});
      chk("pos code", v & 8'h3F, {2'h0, positive_rail.code});
      chk("neg code", ~v & 8'h3F, {2'h0, negative_rail.code});
      rd(8'h0E, v);
    end
    wr(8'h0C, 8'h5A);
    chk("run", 8'h03, {6'h0, positive_rail.run, negative_rail.run});
    wr(8'h0C, 8'h52);
    chk("run", 8'h02, {6'h0, positive_rail.run, negative_rail.run});
    tick(2);
    chk("neg disc", 8'h01, {7'h0, negative_rail.disc});
    tick(30);
    chk("neg float", 8'h00, {7'h0, negative_rail.hold_gnd});
    wr(8'h0C, 8'h74);
    tick(2);
    chk("neg hold", 8'h01, {7'h0, negative_rail.hold_gnd});
    chk("pos hold", 8'h00, {7'h0, positive_rail.hold_gnd});
    wr(8'h09, 8'h20);
    repeat (6) begin
      v = 8'($random(seed));
      plus_enable_pin = v[0];
      minus_enable_pin = v[1];
      tick(1);
      chk("pin run", {6'h0, v[1:0]},
        {6'h0, negative_rail.run, positive_rail.run});
    end
    plus_enable_pin = 1'b1;
    minus_enable_pin = 1'b1;
    tick(8);
    master_enable_pin = 1'b0;
    tick(1);
    chk("shutdown", 8'h04,
      {5'h0, shutdown, positive_rail.run, negative_rail.run});
    tick(30);
    master_enable_pin = 1'b1;
    wr(8'h09, 8'h00);
    for (n = 1; n < 4; n++) begin
      wr(8'h0C, 8'h00);
      wr(8'h0D, {n[1:0], 6'h28});
      tick(40);
      wr(8'h0C, 8'h48);
      k = 0;
      d = dly_cyc(n);
      while (!negative_rail.run && k < 100) begin
        tick(1);
        if (pos_ramp_done) k++;
      end
      chk("up delay", 8'h01, {7'h0, k >= d && k <= d + 2});
      tick(8);
      wr(8'h0C, 8'h00);
      chk("pos held", 8'h01, {7'h0, positive_rail.run});
      tick(40);
    end
    wr(8'h0D, 8'h28);
    wr(8'h0C, 8'hC8);
    tick(4);
    chk("bypass", 8'h0F, {4'h0, boost_rail.run, boost_rail.bypass,
      positive_rail.bypass, negative_rail.bypass});
    wr(8'h0C, 8'h48);
    for (n = 0; n < 2; n++) begin
      wr(8'h08, n ? 8'hC0 : 8'h80);
      tick(40);
      k = 0;
      repeat (n ? T_PERF : T_PERS) begin
        tick(1);
        k += positive_rail.run + negative_rail.run;
      end
      chk("on cycles", 8'(2 * (n ? T_ONF : T_ONS)), 8'(k));
    end
    final_report();
  end
endmodule : display_bias_sequencer_tb
bind dbseq_top dbseq_props #(.DISC_CYC(DISC_CYC)) u_props (
  .core_clk(core_clk), .rst_n(rst_n),
  .master_enable_pin(master_enable_pin), .plus_enable_pin(plus_enable_pin),
  .minus_enable_pin(minus_enable_pin), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .pos_ramp_done(pos_ramp_done), .boost_rail(boost_rail),
  .positive_rail(positive_rail), .negative_rail(negative_rail),
  .shutdown(shutdown));
